// file: blit_pkg.sv
// Constants, field positions and carrier types for the three-operand blit decoder.
// Assumes a single clock domain and a dword-wide graphics memory port.
`default_nettype none
package blit_pkg;
   localparam logic [2:0] CLIENT_2D = 3'h2;
   localparam logic [6:0] OP_COLOR_IMM = 7'h74;
   localparam logic [6:0] OP_MONO_MEM = 7'h56;
   localparam logic [6:0] OP_MONO_IMM = 7'h75;
   localparam logic [7:0] MONO_MEM_LEN = 8'h07;
   localparam logic [7:0] IMM_BASE_LEN = 8'h06;
   localparam logic [7:0] PAT_DW_8 = 8'h10;
   localparam logic [7:0] PAT_DW_16 = 8'h20;
   localparam logic [7:0] PAT_DW_32 = 8'h40;
   localparam int HDR_ALPHA_BIT = 21;
   localparam int HDR_RGB_BIT = 20;
   localparam int HDR_STILE_BIT = 15;
   localparam int HDR_DTILE_BIT = 11;
   localparam int HDR_HSEED_LSB = 12;
   localparam int HDR_VSEED_LSB = 8;
   localparam int HDR_MPOS_LSB = 17;
   localparam int SETUP_CLIP_BIT = 30;
   localparam int SETUP_TRANSP_BIT = 29;
   localparam int SETUP_DEPTH_LSB = 24;
   localparam int SETUP_ROP_LSB = 16;
   localparam int DW_SETUP = 1;
   localparam int DW_DTL = 2;
   localparam int DW_DBR = 3;
   localparam int DW_DBASE = 4;
   localparam int DW_SPITCH = 5;
   localparam int DW_MSRC = 5;
   localparam int DW_STL = 6;
   localparam int DW_BACK = 6;
   localparam int DW_SBASE = 7;
   localparam int DW_FORE = 7;
   localparam int DW_PBASE = 8;
   localparam int DW_IMM = 8;
   localparam int TILE_ROWS_LOG2 = 3;
   localparam int TILE_W_LOG2 = 9;
   localparam int TILE_BYTES_LOG2 = 12;
   localparam int PBASE_LSB = 6;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_CLIP_TL = 12'h008;
   localparam logic [11:0] ADDR_CLIP_BR = 12'h00c;
   localparam logic [11:0] ADDR_PIX_CNT = 12'h010;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam logic [31:0] CLIP_RESET = 32'h00000000;

   typedef enum logic [3:0] {
      S_IDLE, S_FETCH, S_START, S_CHK, S_DRD, S_SRD, S_PRD, S_WR, S_NEXT
   } state_type;

   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } mem_req_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;
endpackage
`default_nettype wire

// file: full_operand_blit_command_decoder.sv
// Three-operand blit command decoder and pixel engine with an APB control slave.
// Assumes commands arrive on a valid/ready dword stream and memory answers with a one-cycle ack.
//
// Functional notes
// [R1] Only headers with client field 02h are executed by this block.
// [R2] Opcode 74h, 56h or 75h selects the variant.
// [R3] At 32 bpp alpha byte written only if bit 21, RGB only if bit 20.
// [R4] Bit 15 source tiling, bit 11 destination tiling; 1 means X-tiled.
// [R5] Pattern pixel (X+hseed) mod 8, row (Y+vseed) mod 8.
// [R6] Color immediate variant length equals 06 plus immediate dword count.
// [R7] Mono memory pattern variant length must be 07h.
// [R8] Immediate pattern holds 16, 32 or 64 dwords by depth.
// [R9] Equal bases and source X1 below destination X1 walk right to left.
// [R10] Equal bases and source Y1 below destination Y1 walk from Y2 upward.
// [R11] With clipping on, only pixels inside clip rectangle are written.
// [R12] Depth from setup bits 25:24, raster operation from bits 23:16.
// [R13] Destination pitch is a signed dword count in setup bits 15:0.
// [R14] Color source pitch is a signed dword count in dword six.
// [R15] Coordinate dwords hold signed Y high and signed X low.
// [R16] Issuer aligns tiled surface bases to 4 Kbytes.
// [R17] Mono transparency suppresses zero bits, else background; one bits use foreground.
// [R18] Mono lines are word aligned and start at header bit position 19:17.
// [R19] Pattern base keeps only bits 28:6 and points to linear memory.
// [R20] Colors use the low 8, 16 or 32 bits by depth.
// [R21] Color immediate variant takes pattern data from the ninth dword onward.
// [R22] Pixels combine bitwise by the raster operation as a three-input table.
`timescale 1ns/100ps
`default_nettype none
module full_operand_blit_command_decoder (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic cmd_valid_in,
   input wire logic [31:0] cmd_data_in,
   output logic cmd_ready_out,
   output blit_pkg::mem_req_type mem_req_out,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in,
   input wire blit_pkg::apb_req_type apb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out
);
   import blit_pkg::*;

   typedef struct packed {
      state_type st;
      logic ready;
      logic enable;
      logic err;
      logic [31:0] clip_tl;
      logic [31:0] clip_br;
      logic [31:0] pix_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [8:0] idx;
      logic [8:0][31:0] cmd;
      logic [63:0][31:0] pat;
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic [31:0] dst_px;
      logic [31:0] src_px;
      logic [31:0] pat_px;
      mem_req_type mem;
   } blit_state_type;

   blit_state_type q;
   blit_state_type d;

   function automatic logic signed [31:0] sx32(input logic [15:0] v);
      sx32 = 32'($signed(v));
   endfunction

   function automatic logic [31:0] surf_addr(input logic [31:0] base, input logic signed [31:0] xb,
                                              input logic signed [31:0] y,
                                              input logic signed [31:0] pitch, input logic tiled);
      logic signed [31:0] off;
      off = 32'sd0;
      if (tiled) begin
         off = ((y >>> TILE_ROWS_LOG2) * pitch * 32'sd32) + ((xb >>> TILE_W_LOG2) <<< TILE_BYTES_LOG2)
             + ((y & 32'sd7) <<< TILE_W_LOG2) + (xb & 32'sd511); // [R4]
      end else begin
         off = y * pitch * 32'sd4 + xb;
      end
      surf_addr = base + $unsigned(off);
   endfunction

   function automatic logic [31:0] rop3(input logic [7:0] raster_operation, input logic [31:0] p,
                                        input logic [31:0] s, input logic [31:0] dv);
      for (int b = 0; b < 32; b++) begin
         rop3[b] = raster_operation[{p[b], s[b], dv[b]}]; // [R22]
      end
   endfunction

   logic [31:0] hdr;
   logic [31:0] setup;
   logic [6:0] opc;
   logic mono;
   logic imm;
   logic [1:0] depth;
   logic signed [31:0] bpb;
   logic [31:0] cmask;
   logic [7:0] cnt;
   logic signed [31:0] dx1, dy1, dx2, dy2, sx1, sy1, cx1, cy1, cx2, cy2;
   logic signed [31:0] xi, yi, ix, ly, x0, y0, xend, yend;
   logic xrev, yrev, cmd_ok, in_clip;
   logic [31:0] daddr, saddr, paddr, maddr, acc_addr;
   logic [31:0] mbit, line_bytes, poff, back_c, fore_c, s_val, p_val, result;
   logic [7:0] pat_need;
   logic [3:0] bemask;
   logic sbit, acc_we, done, apb_hit;

   always_comb begin
      hdr = q.cmd[0];
      setup = q.cmd[DW_SETUP];
      opc = hdr[28:22];
      mono = (opc != OP_COLOR_IMM);
      imm = (opc != OP_MONO_MEM);
      depth = setup[SETUP_DEPTH_LSB +: 2]; // [R12]
      cnt = hdr[7:0];
      bpb = (depth == 2'b11) ? 32'sd4 : ((depth == 2'b00) ? 32'sd1 : 32'sd2);
      cmask = (depth == 2'b11) ? 32'hffffffff : ((depth == 2'b00) ? 32'h000000ff : 32'h0000ffff);
      pat_need = (depth == 2'b11) ? PAT_DW_32 : ((depth == 2'b00) ? PAT_DW_8 : PAT_DW_16); // [R8]
      dx1 = sx32(q.cmd[DW_DTL][15:0]); // [R15]
      dy1 = sx32(q.cmd[DW_DTL][31:16]);
      dx2 = sx32(q.cmd[DW_DBR][15:0]);
      dy2 = sx32(q.cmd[DW_DBR][31:16]);
      sx1 = sx32(q.cmd[DW_STL][15:0]);
      sy1 = sx32(q.cmd[DW_STL][31:16]);
      cx1 = sx32(q.clip_tl[15:0]);
      cy1 = sx32(q.clip_tl[31:16]);
      cx2 = sx32(q.clip_br[15:0]);
      cy2 = sx32(q.clip_br[31:16]);
      xrev = !mono && (q.cmd[DW_SBASE] == q.cmd[DW_DBASE]) && (sx1 < dx1); // [R9]
      yrev = !mono && (q.cmd[DW_SBASE] == q.cmd[DW_DBASE]) && (sy1 < dy1); // [R10]
      x0 = xrev ? dx2 - 32'sd1 : dx1;
      xend = xrev ? dx1 : dx2 - 32'sd1;
      y0 = yrev ? dy2 - 32'sd1 : dy1;
      yend = yrev ? dy1 : dy2 - 32'sd1;
      xi = 32'(q.x);
      yi = 32'(q.y);
      ix = xi - dx1;
      ly = yi - dy1;
      cmd_ok = (hdr[31:29] == CLIENT_2D) && (opc == OP_COLOR_IMM || opc == OP_MONO_MEM
               || opc == OP_MONO_IMM); // [R1] [R2]
      if (opc == OP_MONO_MEM && cnt != MONO_MEM_LEN) begin
         cmd_ok = 1'b0; // [R7]
      end
      if (imm && cnt != IMM_BASE_LEN + pat_need) begin
         cmd_ok = 1'b0; // [R6]
      end
      in_clip = (xi >= cx1) && (xi < cx2) && (yi >= cy1) && (yi < cy2); // [R11]
      daddr = surf_addr(q.cmd[DW_DBASE], xi * bpb, yi, sx32(setup[15:0]), hdr[HDR_DTILE_BIT]); // [R13]
      saddr = surf_addr(q.cmd[DW_SBASE], (sx1 + ix) * bpb, sy1 + ly, sx32(q.cmd[DW_SPITCH][15:0]),
                        hdr[HDR_STILE_BIT]); // [R14]
      mbit = 32'(hdr[HDR_MPOS_LSB +: 3]) + $unsigned(ix);
      line_bytes = ((32'(hdr[HDR_MPOS_LSB +: 3]) + $unsigned(dx2 - dx1) + 32'd15) >> 4) << 1; // [R18]
      maddr = q.cmd[DW_MSRC] + $unsigned(ly) * line_bytes + (mbit >> 3);
      poff = (({29'd0, 3'(q.y + 16'(hdr[HDR_VSEED_LSB +: 3]))} << 3)
             + {29'd0, 3'(q.x + 16'(hdr[HDR_HSEED_LSB +: 3]))}) * $unsigned(bpb); // [R5]
      paddr = {3'b000, q.cmd[DW_PBASE][28:PBASE_LSB], 6'b000000} + poff; // [R19]
      back_c = q.cmd[DW_BACK] & cmask; // [R20]
      fore_c = q.cmd[DW_FORE] & cmask;
      sbit = q.src_px[0];
      s_val = mono ? (sbit ? fore_c : back_c) : q.src_px; // [R17]
      p_val = imm ? ((q.pat[poff[7:2]] >> {poff[1:0], 3'b000}) & cmask) : q.pat_px; // [R21]
      result = rop3(setup[SETUP_ROP_LSB +: 8], p_val, s_val, q.dst_px) & cmask;
      if (depth == 2'b11) begin
         bemask = {hdr[HDR_ALPHA_BIT], {3{hdr[HDR_RGB_BIT]}}}; // [R3]
      end else begin
         bemask = (depth == 2'b00) ? 4'h1 : 4'h3;
      end
      case (q.st)
         S_SRD: acc_addr = mono ? maddr : saddr;
         S_PRD: acc_addr = paddr;
         default: acc_addr = daddr;
      endcase
      acc_we = (q.st == S_WR);
   end

   always_comb begin
      d = q;
      done = 1'b0;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      apb_hit = (apb_in.paddr == ADDR_CTRL) || (apb_in.paddr == ADDR_STATUS)
                || (apb_in.paddr == ADDR_CLIP_TL) || (apb_in.paddr == ADDR_CLIP_BR)
                || (apb_in.paddr == ADDR_PIX_CNT);
      if (apb_in.psel && apb_in.penable && !q.pready) begin
         d.pready = 1'b1;
         d.pslverr = !apb_hit;
         case (apb_in.paddr)
            ADDR_CTRL: d.prdata = {31'd0, q.enable};
            ADDR_STATUS: d.prdata = {16'd0, 1'b0, opc, 6'd0, q.err, (q.st != S_IDLE)};
            ADDR_CLIP_TL: d.prdata = q.clip_tl;
            ADDR_CLIP_BR: d.prdata = q.clip_br;
            ADDR_PIX_CNT: d.prdata = q.pix_cnt;
            default: d.prdata = 32'h00000000;
         endcase
      end
      if (apb_in.psel && apb_in.penable && q.pready && apb_in.pwrite) begin
         case (apb_in.paddr)
            ADDR_CTRL: d.enable = apb_in.pwdata[0];
            ADDR_STATUS: d.err = q.err && !apb_in.pwdata[1];
            ADDR_CLIP_TL: d.clip_tl = apb_in.pwdata;
            ADDR_CLIP_BR: d.clip_br = apb_in.pwdata;
            default: d.err = d.err;
         endcase
      end
      if (q.st == S_DRD || q.st == S_SRD || q.st == S_PRD || q.st == S_WR) begin
         if (!q.mem.valid) begin
            d.mem.valid = 1'b1;
            d.mem.we = acc_we;
            d.mem.addr = {acc_addr[31:2], 2'b00};
            d.mem.be = bemask << acc_addr[1:0];
            d.mem.wdata = result << {acc_addr[1:0], 3'b000};
         end else if (mem_ack_in) begin
            d.mem.valid = 1'b0;
            done = 1'b1;
         end
      end
      case (q.st)
         S_IDLE: begin
            d.ready = d.enable;
            if (q.ready && cmd_valid_in) begin
               d.cmd[0] = cmd_data_in;
               d.idx = 9'h001;
               d.st = S_FETCH;
            end
         end
         S_FETCH: begin
            if (cmd_valid_in) begin
               if (q.idx <= 9'h008) begin
                  d.cmd[q.idx[3:0]] = cmd_data_in;
               end
               if (imm && q.idx >= 9'(DW_IMM) && q.idx < 9'(DW_IMM + 64)) begin
                  d.pat[6'(q.idx - 9'(DW_IMM))] = cmd_data_in; // [R21]
               end
               if (q.idx == {1'b0, cnt} + 9'h001) begin
                  d.ready = 1'b0; // [R6] [R7]
                  d.st = S_START;
               end else begin
                  d.idx = q.idx + 9'h001;
               end
            end
         end
         S_START: begin
            if (!cmd_ok) begin
               d.err = 1'b1;
               d.st = S_IDLE;
            end else if (dx2 <= dx1 || dy2 <= dy1) begin
               d.st = S_IDLE;
            end else begin
               d.x = 16'(x0);
               d.y = 16'(y0);
               d.st = S_CHK;
            end
         end
         S_CHK: begin
            d.st = (setup[SETUP_CLIP_BIT] && !in_clip) ? S_NEXT : S_DRD; // [R11]
         end
         S_DRD: begin
            if (done) begin
               d.dst_px = (mem_rdata_in >> {daddr[1:0], 3'b000}) & cmask;
               d.st = S_SRD;
            end
         end
         S_SRD: begin
            if (done) begin
               if (mono) begin
                  d.src_px = {31'd0, mem_rdata_in[{maddr[1:0], 3'b000} + (5'd7 - 5'(mbit[2:0]))]};
               end else begin
                  d.src_px = (mem_rdata_in >> {saddr[1:0], 3'b000}) & cmask;
               end
               d.st = imm ? S_WR : S_PRD;
            end
         end
         S_PRD: begin
            if (done) begin
               d.pat_px = (mem_rdata_in >> {paddr[1:0], 3'b000}) & cmask;
               d.st = S_WR;
            end
         end
         S_WR: begin
            if (mono && !sbit && setup[SETUP_TRANSP_BIT] && !q.mem.valid) begin
               d.mem.valid = 1'b0; // [R17]
               d.st = S_NEXT;
            end else if (bemask == 4'h0 && !q.mem.valid) begin
               d.mem.valid = 1'b0; // [R3]
               d.st = S_NEXT;
            end else if (done) begin
               d.pix_cnt = q.pix_cnt + 32'd1;
               d.st = S_NEXT;
            end
         end
         S_NEXT: begin
            if (xi != xend) begin
               d.x = xrev ? q.x - 16'sd1 : q.x + 16'sd1; // [R9]
               d.st = S_CHK;
            end else if (yi != yend) begin
               d.x = 16'(x0);
               d.y = yrev ? q.y - 16'sd1 : q.y + 16'sd1; // [R10]
               d.st = S_CHK;
            end else begin
               d.st = S_IDLE;
            end
         end
         default: d.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q <= '0;
         q.st <= S_IDLE;
         q.enable <= CTRL_ENABLE_RESET;
         q.clip_tl <= CLIP_RESET;
         q.clip_br <= CLIP_RESET;
      end else begin
         q <= d;
      end
   end

   assign cmd_ready_out = q.ready;
   assign mem_req_out = q.mem;
   assign prdata_out = q.prdata;
   assign pready_out = q.pready;
   assign pslverr_out = q.pslverr;
endmodule
`default_nettype wire

// file: blit_sva.sv
// Port checker for the blit decoder: memory handshake, command stream and APB timing.
// Assumes one clock domain and the carrier types of blit_pkg.
`timescale 1ns/100ps
`default_nettype none
module blit_sva (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic cmd_valid_in,
   input wire logic [31:0] cmd_data_in,
   input wire logic cmd_ready_out,
   input wire blit_pkg::mem_req_type mem_req_out,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in,
   input wire blit_pkg::apb_req_type apb_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out
);
   import blit_pkg::*;
   default clocking dcb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);
   a_req_hold: assert property (mem_req_out.valid && !mem_ack_in |=> $stable(mem_req_out))
      else $error("memory request changed before ack");
   a_req_drop: assert property (mem_req_out.valid && mem_ack_in |=> !mem_req_out.valid)
      else $error("memory request kept after ack");
   a_load_no_mem: assert property (cmd_ready_out |-> !mem_req_out.valid)
      else $error("memory access while taking command dwords");
   a_addr_align: assert property (mem_req_out.valid |-> mem_req_out.addr[1:0] == 2'b00)
      else $error("memory address not dword aligned");
   a_write_mask: assert property (mem_req_out.valid && mem_req_out.we |-> mem_req_out.be != 4'h0)
      else $error("write with no byte enabled");
   a_apb_latency: assert property (apb_in.psel && !apb_in.penable |=> !pready_out ##1 pready_out)
      else $error("apb ready not in second access cycle");
   a_apb_pulse: assert property (pready_out |=> !pready_out)
      else $error("apb ready longer than one cycle");
   a_err_pair: assert property (pslverr_out |-> pready_out)
      else $error("apb error without ready");
   a_unmapped_err: assert property (pready_out && apb_in.paddr > ADDR_PIX_CNT
      |-> pslverr_out && prdata_out == 32'h0)
      else $error("unmapped apb access not refused");
   c_write: cover property (mem_req_out.valid && mem_req_out.we && mem_ack_in);
   c_refused: cover property (pready_out && pslverr_out);
   c_cmd_done: cover property ($rose(cmd_ready_out));
endmodule
bind full_operand_blit_command_decoder blit_sva u_sva (
   .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in),
   .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out), .mem_req_out(mem_req_out),
   .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .apb_in(apb_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));
`default_nettype wire

// file: mem_model.sv
// Graphics memory model: linear dword array answering after a chosen number of cycles.
// Assumes the request is held until the ack and dropped on the edge after it.
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire blit_pkg::mem_req_type req_in,
   input wire logic [3:0] lat_in,
   output logic ack_out,
   output logic [31:0] rdata_out
);
   import blit_pkg::*;
   logic [31:0] mem [0:255];
   logic [3:0] wait_q;
   initial begin
      foreach (mem[i]) mem[i] = 32'h0;
   end
   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ack_out <= 1'b0;
         wait_q <= 4'h0;
         rdata_out <= 32'h0;
      end else begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
         if (req_in.valid && !ack_out) begin
            if (wait_q >= lat_in) begin
               ack_out <= 1'b1;
               wait_q <= 4'h0;
               rdata_out <= mem[req_in.addr[9:2]];
               for (int b = 0; b < 4; b++) begin
                  if (req_in.we && req_in.be[b]) begin
                     mem[req_in.addr[9:2]][8*b+:8] <= req_in.wdata[8*b+:8];
                  end
               end
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the blit decoder with APB master and memory model.
// Assumes the decoder and mem_model are compiled; runs at 10 MHz.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import blit_pkg::*;
   logic clk_sys_in, reset_n_in, cmd_valid_in, cmd_ready_out, mem_ack_in;
   logic pready_out, pslverr_out, err;
   logic [31:0] cmd_data_in, mem_rdata_in, prdata_out, rd;
   logic [3:0] lat;
   mem_req_type mem_req_out;
   apb_req_type apb_in;
   mem_req_type wq[$];
   logic [31:0] cmd [0:7];
   int errors = 0;
   int n_tests = 0;
   full_operand_blit_command_decoder u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .cmd_valid_in(cmd_valid_in), .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out),
      .mem_req_out(mem_req_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
      .apb_in(apb_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out));
   mem_model u_mem (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .req_in(mem_req_out),
      .lat_in(lat), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      if (mem_req_out.valid && mem_req_out.we && mem_ack_in) wq.push_back(mem_req_out);
   end
   task report_and_stop;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys_in);
      apb_in <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys_in);
      apb_in.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (!pready_out && n < 20);
      if (n >= 20) begin
         errors++;
         report_and_stop;
      end
      rd = prdata_out;
      err = pslverr_out;
      apb_in <= '0;
   endtask
   task send(input int n);
      int w;
      for (int i = 0; i < n; i++) begin
         cmd_valid_in <= 1'b1;
         cmd_data_in <= (i < 8) ? cmd[i] : 32'ha0000000 + 32'(i - 8);
         w = 0;
         do begin
            @(posedge clk_sys_in);
            w++;
         end while (!cmd_ready_out && w < 50);
         if (w >= 50) begin
            errors++;
            report_and_stop;
         end
      end
      cmd_valid_in <= 1'b0;
      w = 0;
      while (cmd_ready_out && w < 4) begin
         @(posedge clk_sys_in);
         w++;
      end
      w = 0;
      while (!cmd_ready_out && w < 3000) begin
         @(posedge clk_sys_in);
         w++;
      end
      if (w >= 3000) begin
         errors++;
         report_and_stop;
      end
   endtask
   task t_regs;
      apb(1'b0, ADDR_CTRL, 32'h0);
      cmp("ctrl enable", 32'h1, {31'h0, rd[0]});
      apb(1'b0, ADDR_CLIP_TL, 32'h0);
      cmp("clip_tl", CLIP_RESET, rd);
      apb(1'b1, ADDR_CLIP_TL, 32'h00000002);
      apb(1'b1, ADDR_CLIP_BR, 32'h00010003);
      apb(1'b0, ADDR_CLIP_BR, 32'h0);
      cmp("clip_br", 32'h00010003, rd);
      apb(1'b0, 12'h020, 32'h0);
      cmp("unmapped err", 32'h1, {31'h0, err});
      cmp("unmapped data", 32'h0, rd);
   endtask
   task t_alpha;
      cmd[0] = {CLIENT_2D, OP_COLOR_IMM, 2'b01, 5'h0, 3'h3, 1'b0, 3'h2, 8'h46};
      cmd[1] = {8'h03, 8'hf0, 16'h0010};
      cmd[2] = 32'h0;
      cmd[3] = 32'h00010001;
      cmd[4] = 32'h100;
      cmd[5] = 32'h10;
      cmd[6] = 32'h0;
      cmd[7] = 32'h200;
      wq.delete();
      send(72);
      cmp("writes", 32'h1, 32'(wq.size()));
      cmp("byte mask", 32'h7, {28'h0, wq[0].be});
      cmp("pattern pixel", 32'h13, {8'h0, wq[0].wdata[23:0]});
      cmp("dest addr", 32'h100, wq[0].addr);
      apb(1'b0, ADDR_PIX_CNT, 32'h0);
      cmp("pix_cnt", 32'h1, rd);
   endtask
   task t_bad(input logic [2:0] cl, input logic [6:0] op, input logic [7:0] len);
      cmd[0] = {cl, op, 14'h0, len};
      cmd[1] = {8'h00, 8'hf0, 16'h0010};
      wq.delete();
      send(int'(len) + 2);
      cmp("bad writes", 32'h0, 32'(wq.size()));
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp("err set", 32'h1, {31'h0, rd[1]});
      apb(1'b1, ADDR_STATUS, 32'h2);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp("err clear", 32'h0, {31'h0, rd[1]});
   endtask
   task t_overlap(input logic clip, input int n);
      cmd[0] = {CLIENT_2D, OP_COLOR_IMM, 14'h0, 8'd22};
      cmd[1] = {1'b0, clip, 6'h0, 8'hcc, 16'h0010};
      cmd[2] = 32'h1;
      cmd[3] = 32'h00010003;
      cmd[7] = 32'h100;
      wq.delete();
      send(24);
      cmp("overlap writes", 32'(n), 32'(wq.size()));
      cmp("first lane", 32'h4, {28'h0, wq[0].be});
      if (n == 2) cmp("second lane", 32'h2, {28'h0, wq[1].be});
   endtask
   task t_mono(input logic tr);
      lat <= 4'h3;
      cmd[0] = {CLIENT_2D, OP_MONO_MEM, 14'h0, MONO_MEM_LEN};
      cmd[1] = {2'b00, tr, 5'h0, 8'hcc, 16'h0010};
      cmd[2] = 32'h0;
      cmd[3] = 32'h00010001;
      cmd[5] = 32'h200;
      cmd[6] = 32'h5a5a5a3c;
      cmd[7] = 32'h77;
      wq.delete();
      send(9);
      cmp("mono writes", {31'h0, !tr}, 32'(wq.size()));
      if (!tr) cmp("background", 32'h3c, {24'h0, wq[0].wdata[7:0]});
   endtask
   initial begin
      reset_n_in = 1'b0;
      cmd_valid_in = 1'b0;
      cmd_data_in = 32'h0;
      apb_in = '0;
      lat = 4'h0;
      repeat (4) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      t_regs;
      t_alpha;
      t_bad(3'h3, OP_COLOR_IMM, 8'd22);
      t_bad(CLIENT_2D, OP_COLOR_IMM, 8'd21);
      t_bad(CLIENT_2D, 7'h55, 8'h07);
      t_bad(CLIENT_2D, OP_MONO_MEM, 8'h08);
      t_overlap(1'b0, 2);
      t_overlap(1'b1, 1);
      t_mono(1'b1);
      t_mono(1'b0);
      report_and_stop;
   end
endmodule
`default_nettype wire
